// ===== src/ext_irq_pkg.sv
/*
 Package for the external interrupt pin edge detection and debounce block.
 Holds widths, reset values, sense encodings and the per-line config struct.
 Assumes a single 25 MHz core clock shared by every user of these names.
*/
package ext_irq_pkg;

   // Number of external interrupt lines.
   localparam int NUM_LINES_DEF = 8;
   // Width of a debounce prescaler field; tick every 2^(n+1) clocks.
   localparam int PRESC_W = 3;
   // Width of the prescaler counter, wide enough for the largest divide.
   localparam int DIV_W = 9;
   // Width of the per-line transition counter.
   localparam int TCNT_W = 4;
   // Transition count thresholds.
   localparam logic [TCNT_W-1:0] THRESH_LOW  = 4'h4;
   localparam logic [TCNT_W-1:0] THRESH_HIGH = 4'h8;
   // Reset values of the transition counter and the valid pin state.
   localparam logic [TCNT_W-1:0] TCNT_RESET  = 4'h0;
   localparam logic              VALID_RESET = 1'b0;

   // Sense selection of one line.
   typedef enum logic [2:0]
   {
      SENSE_NONE = 3'h0,
      SENSE_RISE = 3'h1,
      SENSE_FALL = 3'h2,
      SENSE_BOTH = 3'h3,
      SENSE_HIGH = 3'h4,
      SENSE_LOW  = 3'h5
   } sense_t;

   // Configuration of one line as software sets it.
   typedef struct packed
   {
      sense_t sense_select;      // Which edge or level sets the flag.
      logic   debounce_enable;   // Route the line through the debouncer.
      logic   filter_enable;     // Filter enable, not acted on by the controller; not combined with debounce.
   } line_cfg_t;

   // Debouncer global settings.
   typedef struct packed
   {
      logic [PRESC_W-1:0] debounce_prescaler; // Tick rate selector.
      logic               bounce_on_tick;     // Check bounces only on ticks.
      logic               state_count_select; // Sync lines 0: four, 1: eight ticks; async four.
   } debounce_cfg_t;

endpackage : ext_irq_pkg

// ===== src/ext_irq_controller.sv
/*
 External interrupt pin edge detection with optional debouncer.
 Assumes pins are synchronous to core_clk; for an undebounced line with an edge
 sense the "asynchronous" path sets the flag combinationally from the pin into the
 flag flop's next value, so it does not wait on a sampling stage; level senses use
 the clocked sample. Sleep handling is outside: this block has no
 sleep input and so keeps detecting in every sleep state. Flags are cleared by
 a per-line clear strobe; a set in the same cycle wins.
*/
// Function
// RL1 - Async bit zero selects synchronous detection
// RL2 - Sync mode flags on sample change
// RL3 - Request clock while any sync line
// RL4 - Async mode sets flag without sampling
// RL5 - Detection keeps working in sleep modes
// RL6 - Debouncer style follows async bit
// RL7 - Prescaler derives low frequency debounce tick
// RL8 - Software debounces only edge senses
// RL9 - Valid state kept, pin sampled continuously
// RL10 - Tick sample differing counts a transition
// RL11 - Bounce resets counter, per clock or tick
// RL12 - Threshold four or eight, async four
// RL13 - Edge validated after threshold passes
// RL14 - Debounced state readable by software; the NMI line's debounced state has no output
// RL15 - Validated edge updates state, maybe flags
// RL16 - Counter and state reset to zero
`timescale 1ns/100ps
`default_nettype none
module ext_irq_controller
   import ext_irq_pkg::*;
#(
   parameter int NUM_LINES = NUM_LINES_DEF
)
(
   // Clock and reset.
   input  wire logic                  core_clk,
   input  wire logic                  resetn,
   // Pins.
   input  wire logic [NUM_LINES-1:0]  ext_irq_pin,
   input  wire logic                  nmi_pin,
   // Configuration.
   input  wire logic [NUM_LINES-1:0]  async_mode_bits,
   input  wire logic                  nmi_async,
   input  wire line_cfg_t             line_cfg [NUM_LINES],
   input  wire line_cfg_t             nmi_cfg,
   input  wire debounce_cfg_t         deb_cfg,
   // Flag clears.
   input  wire logic [NUM_LINES-1:0]  irq_flag_clear,
   input  wire logic                  nmi_flag_clear,
   // Status.
   output logic [NUM_LINES-1:0]       irq_flag_reg,
   output logic                       nonmaskable_flag,
   output logic [NUM_LINES-1:0]       debounced_state_reg,
   output logic                       clock_request
);

   // Refuse configurations the counters cannot serve; the line vectors are
   // sized for at most 32 lines plus the non-maskable line on top.
   if (NUM_LINES < 1 || NUM_LINES > 32)
   begin : g_bad_lines
      $error("NUM_LINES out of range");
   end

   // Lines including the NMI as the top index.
   localparam int L = NUM_LINES + 1;

   logic [L-1:0]       pin_all;        // Pins with the NMI on top.
   logic [L-1:0]       async_all;      // Async bits with the NMI on top.
   line_cfg_t          cfg_all [L];    // Configs with the NMI on top.
   logic [L-1:0]       clr_all;        // Clears with the NMI on top.

   always_comb
   begin
      pin_all   = {nmi_pin, ext_irq_pin};
      async_all = {nmi_async, async_mode_bits};
      clr_all   = {nmi_flag_clear, irq_flag_clear};
      for (int i = 0; i < NUM_LINES; i++)
         cfg_all[i] = line_cfg[i];
      cfg_all[NUM_LINES] = nmi_cfg;
   end

   logic [L-1:0]        sample;          // Latest clocked sample.
   logic [L-1:0]        prev;            // Previous clocked sample.
   logic [L-1:0]        flag;            // Interrupt flags.
   logic [L-1:0]        valid;           // Debounced valid pin state.
   logic [TCNT_W-1:0]   tcnt [L];        // Transition counters.
   logic [DIV_W-1:0]    div;             // Prescaler counter.
   logic                clk_req;         // Registered clock request.
   logic [L-1:0]        next_sample;
   logic [L-1:0]        next_prev;
   logic [L-1:0]        next_flag;
   logic [L-1:0]        next_valid;
   logic [TCNT_W-1:0]   next_tcnt [L];
   logic [DIV_W-1:0]    next_div;
   logic                next_clk_req;
   logic                tick;            // Low frequency tick enable.
   logic [DIV_W-1:0]    div_mask;        // Terminal count of the prescaler.

   // Prescaler: one tick every 2^(field+1) core clocks.
   always_comb
   begin
      div_mask = DIV_W'((1 << (deb_cfg.debounce_prescaler + 1)) - 1); // RL7
      tick     = ((div & div_mask) == div_mask);                       // RL7
      next_div = div + 1'b1;
   end

   // Per-line detection, debounce and flag logic.
   // Every line, the non-maskable one included, runs through the same loop body.
   // Nothing here depends on a sleep state: the block has no sleep input, so
   // detection carries on in Idle and Standby as long as core_clk runs.
   // The filter enable bit is not acted on; software keeps it off when
   // debouncing, so the debouncer alone shapes a debounced line.
   always_comb
   begin
      logic            lvl;
      logic            edge_r;
      logic            edge_f;
      logic            hit;
      logic [TCNT_W-1:0] thr;
      lvl    = 1'b0;
      edge_r = 1'b0;
      edge_f = 1'b0;
      hit    = 1'b0;
      thr    = THRESH_LOW;
      next_sample  = pin_all;                   // RL9
      next_prev    = sample;
      next_valid   = valid;
      next_clk_req = 1'b0;
      for (int i = 0; i < L; i++)
      begin
         next_tcnt[i] = tcnt[i];
         edge_r = 1'b0;
         edge_f = 1'b0;
         // A cleared async bit, the reset default, means clocked detection.
         if (!async_all[i])
            next_clk_req = 1'b1;                // RL1 RL3
         if (cfg_all[i].debounce_enable)
         begin
            // Async style always counts to four.
            // The style is chosen per line by its own async bit.
            if (!async_all[i] && deb_cfg.state_count_select)
               thr = THRESH_HIGH;               // RL6 RL12
            else
               thr = THRESH_LOW;                // RL12
            if (sample[i] == valid[i])
            begin
               if (!deb_cfg.bounce_on_tick || tick)
                  next_tcnt[i] = TCNT_RESET;    // RL11
            end
            else if (tick)
            begin
               if (tcnt[i] + 1'b1 >= thr)       // RL13
               begin
                  next_valid[i] = sample[i];    // RL15
                  next_tcnt[i]  = TCNT_RESET;
                  edge_r = sample[i];
                  edge_f = !sample[i];
               end
               else
                  next_tcnt[i] = tcnt[i] + 1'b1; // RL10
            end
         end
         else if (async_all[i])                 // RL1
         begin
            // Trade-off: the raw pin feeds the flag's next value, so the flag
            // follows one edge after the pin change instead of two.
            // Direct edge from the pin against the last seen level.
            edge_r = pin_all[i] && !sample[i];  // RL4
            edge_f = !pin_all[i] && sample[i];  // RL4
         end
         else
         begin
            edge_r = sample[i] && !prev[i];     // RL2
            edge_f = !sample[i] && prev[i];     // RL2
         end
         // Match the edge or level to the sense setting.
         case (cfg_all[i].sense_select)
            SENSE_RISE: hit = edge_r;
            SENSE_FALL: hit = edge_f;
            SENSE_BOTH: hit = edge_r || edge_f;
            SENSE_HIGH: hit = sample[i];
            SENSE_LOW:  hit = !sample[i];
            default:    hit = 1'b0;
         endcase
         lvl = hit;
         // Set wins over a clear in the same cycle.
         next_flag[i] = lvl || (flag[i] && !clr_all[i]); // RL15
      end
   end

   // Registers; counter and valid state start cleared.
   // The reset branch loads constants only, so a glitch on resetn can never
   // copy a half-settled input into the state. These flops keep running in
   // every sleep state, which keeps detection alive there.
   always_ff @(posedge core_clk or negedge resetn) // RL5
   begin
      if (!resetn)
      begin
         sample  <= '0;
         prev    <= '0;
         flag    <= '0;
         valid   <= {L{VALID_RESET}};           // RL16
         div     <= '0;
         clk_req <= 1'b0;
         for (int i = 0; i < L; i++)
            tcnt[i] <= TCNT_RESET;              // RL16
      end
      else
      begin
         sample  <= next_sample;
         prev    <= next_prev;
         flag    <= next_flag;
         valid   <= next_valid;
         div     <= next_div;
         clk_req <= next_clk_req;
         for (int i = 0; i < L; i++)
            tcnt[i] <= next_tcnt[i];
      end
   end

   // Outputs come straight from flops.
   // Only the ordinary lines leave on the vector ports; the non-maskable line
   // sits on the top index and has its own flag port.
   assign irq_flag_reg        = flag[NUM_LINES-1:0];
   assign nonmaskable_flag    = flag[NUM_LINES];
   assign debounced_state_reg = valid[NUM_LINES-1:0]; // RL14
   assign clock_request       = clk_req;             // RL3

endmodule : ext_irq_controller
`default_nettype wire

// ===== bench/irq_pin_board.sv
/*
 Board model for the external interrupt pins, NMI on bit 8.
 Assumes the bench sets levels just after a falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module irq_pin_board
(
   // Clock and commands.
   input  wire logic       core_clk,
   input  wire logic [8:0] level,
   input  wire logic       bounce,
   // Pins.
   output logic      [8:0] pins
);
   logic toggle = 1'b0; // Chatter phase of line 2.
   logic next_toggle;   // Flips each clock while bouncing.
   // A worn contact flips line 2 every clock, so no tick window ever settles.
   always_comb next_toggle = bounce & ~toggle;
   // Moves by non-blocking assignment on the rising edge, so the block still
   // samples the old level there and the bench's falling-edge command is settled.
   always_ff @(posedge core_clk) toggle <= next_toggle;
   assign pins = level ^ {6'h00, toggle, 2'h0};
endmodule : irq_pin_board
`default_nettype wire

// ===== bench/ext_irq_controller_assertions.sv
/*
 Port checker for ext_irq_controller.
 Assumes line configurations stay fixed while pins move.
*/
`timescale 1ns/100ps
`default_nettype none
module ext_irq_checks
   import ext_irq_pkg::*;
#(parameter int NUM_LINES = NUM_LINES_DEF)
(
   // Block inputs.
   input wire logic                 core_clk,
   input wire logic                 resetn,
   input wire logic [NUM_LINES-1:0] ext_irq_pin,
   input wire logic                 nmi_pin,
   input wire logic [NUM_LINES-1:0] async_mode_bits,
   input wire logic                 nmi_async,
   input wire line_cfg_t            line_cfg [NUM_LINES],
   input wire line_cfg_t            nmi_cfg,
   input wire logic                 nmi_flag_clear,
   // Block outputs.
   input wire logic [NUM_LINES-1:0] irq_flag_reg,
   input wire logic                 nonmaskable_flag,
   input wire logic [NUM_LINES-1:0] debounced_state_reg,
   input wire logic                 clock_request
);
   logic [4:0] diff_cnt;      // Clocks line 2 has disagreed with its valid state.
   logic [4:0] next_diff_cnt; // A flip of the state clears it, so no saturation.
   logic       all_async_q;   // Every line async, as seen one edge ago.
   // Count disagreement so an early flip of the valid state shows up.
   always_comb next_diff_cnt = (ext_irq_pin[2] != debounced_state_reg[2]) ?
                               diff_cnt + 5'h01 : 5'h00;
   always_ff @(posedge core_clk or negedge resetn)
      if (!resetn)
      begin
         diff_cnt    <= 5'h00;
         all_async_q <= 1'b0;
      end
      else
      begin
         diff_cnt    <= next_diff_cnt;
         all_async_q <= &{nmi_async, async_mode_bits};
      end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_clk_req_sync: assert property ($past(resetn) |->
      clock_request == !all_async_q) else $error("clock request wrong");
   a_sync_edge_flag: assert property (!async_mode_bits[0] &&
      line_cfg[0].sense_select == SENSE_BOTH && $changed(ext_irq_pin[0]) |-> ##[1:3]
      irq_flag_reg[0]) else $error("sync edge lost");
   a_async_edge_flag: assert property (async_mode_bits[1] && $changed(ext_irq_pin[1])
      |-> ##1 irq_flag_reg[1]) else $error("async edge late");
   a_nmi_edge_flag: assert property (!nmi_async && nmi_cfg.sense_select == SENSE_RISE
      && $rose(nmi_pin) |-> ##2 nonmaskable_flag) else $error("nmi edge lost");
   a_nmi_flag_holds: assert property (nonmaskable_flag && !nmi_flag_clear
      |=> nonmaskable_flag) else $error("nmi flag dropped");
   a_none_stays_quiet: assert property (line_cfg[4].sense_select == SENSE_NONE
      && !irq_flag_reg[4] |=> !irq_flag_reg[4]) else $error("flag without sense");
   a_deb_min_time: assert property ($changed(debounced_state_reg[2])
      |-> $past(diff_cnt) >= 5'h04) else $error("debounce too quick");
   a_reset_clears_all: assert property (disable iff (1'b0) !resetn |->
      !(|{irq_flag_reg, nonmaskable_flag, debounced_state_reg, clock_request}))
      else $error("outputs set in reset");
endmodule : ext_irq_checks
bind ext_irq_controller ext_irq_checks #(.NUM_LINES(NUM_LINES)) i_checks (.core_clk, .resetn,
   .ext_irq_pin, .nmi_pin, .async_mode_bits, .nmi_async, .line_cfg, .nmi_cfg,
   .nmi_flag_clear, .irq_flag_reg, .nonmaskable_flag, .debounced_state_reg, .clock_request);
`default_nettype wire

// ===== bench/test_ext_irq_controller.sv
/*
 Bench for ext_irq_controller: pin sequences with expected flags.
 Assumes the board model drives the pins and the checker is bound.
*/
`timescale 1ns/100ps
`default_nettype none
module test_ext_irq_controller
   import ext_irq_pkg::*;
;
   logic          core_clk, resetn, bounce, nmi_async, nmi_flag_clear;
   logic          nonmaskable_flag, clock_request;
   logic [8:0]    level, pins;
   logic [7:0]    async_mode_bits, irq_flag_clear, irq_flag_reg, debounced_state_reg;
   line_cfg_t     line_cfg [8];
   line_cfg_t     nmi_cfg;
   debounce_cfg_t deb_cfg;
   int            err_total, n_tests;
   // Every sense code, SENSE_BOTH on lines 0 to 2; only line 2 is debounced, with an edge sense.
   sense_t        senses [8] = '{SENSE_BOTH, SENSE_BOTH, SENSE_BOTH, SENSE_RISE,
                                 SENSE_NONE, SENSE_FALL, SENSE_HIGH, SENSE_LOW};
   ext_irq_controller i_dut (.core_clk, .resetn, .ext_irq_pin(pins[7:0]), .nmi_pin(pins[8]),
      .async_mode_bits, .nmi_async, .line_cfg, .nmi_cfg, .deb_cfg, .irq_flag_clear,
      .nmi_flag_clear, .irq_flag_reg, .nonmaskable_flag, .debounced_state_reg, .clock_request);
   irq_pin_board i_board (.core_clk, .level, .bounce, .pins);
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // Inputs move only at falling edges, away from the sampling edge.
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask : cyc
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic results();
      if (err_total == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results
   initial
   begin
      {resetn, bounce, nmi_async, nmi_flag_clear, level, irq_flag_clear} = 21'h000000;
      async_mode_bits = 8'h02;
      nmi_cfg = '{SENSE_RISE, 1'b0, 1'b0};
      deb_cfg = '{3'h0, 1'b0, 1'b0};
      err_total = 0;
      n_tests = 0;
      foreach (line_cfg[i]) line_cfg[i] = '{senses[i], i == 2, 1'b0};
      cyc(20);
      resetn = 1'b1;
      cyc(3);
      chk(clock_request, 9'h001);
      level = 9'h16B;
      cyc(4);
      chk(irq_flag_reg, 9'h0CB);
      chk(nonmaskable_flag, 9'h001);
      irq_flag_clear = 8'hFF;
      nmi_flag_clear = 1'b1;
      cyc(1);
      {irq_flag_clear, nmi_flag_clear} = 9'h000;
      cyc(2);
      chk({irq_flag_reg, nonmaskable_flag}, 9'h180);
      level = 9'h000;
      cyc(4);
      chk(irq_flag_reg, 9'h0E3);
      async_mode_bits = 8'hFF;
      nmi_async = 1'b1;
      cyc(2);
      chk(clock_request, 9'h000);
      async_mode_bits = 8'h02;
      nmi_async = 1'b0;
      bounce = 1'b1;
      cyc(20);
      bounce = 1'b0;
      cyc(2);
      chk({debounced_state_reg[2], irq_flag_reg[2]}, 9'h000);
      level = 9'h004;
      cyc(6);
      chk(debounced_state_reg[2], 9'h000);
      cyc(6);
      chk({debounced_state_reg[2], irq_flag_reg[2]}, 9'h003);
      deb_cfg.state_count_select = 1'b1;
      level = 9'h000;
      cyc(12);
      chk(debounced_state_reg[2], 9'h001);
      cyc(12);
      chk(debounced_state_reg[2], 9'h000);
      resetn = 1'b0;
      cyc(1);
      chk({irq_flag_reg, nonmaskable_flag}, 9'h000);
      resetn = 1'b1;
      cyc(2);
      results();
   end
endmodule : test_ext_irq_controller
`default_nettype wire
